// File: testbench/cwu_bridge_model.sv
`timescale 1ns/100ps
`default_nettype none
module cwu_bridge_model (
  // Clock and reset
  input  wire logic clk_sys_in,
  input  wire logic rst_n_in,
  // Leg gate drives
  input  wire logic arm_in,
  input  wire logic [3:0] pins_in,
  // Sticky shoot-through flag
  output logic      overlap_out
);
  // Both switches of one leg on at once would short the supply
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      overlap_out <= 1'b0;
    end else if (arm_in && (&pins_in[1:0] || &pins_in[3:2])) begin
      overlap_out <= 1'b1;
    end
  end
endmodule : cwu_bridge_model
`default_nettype wire

// File: testbench/cwu_top_properties.sv
`timescale 1ns/100ps
`default_nettype none
module cwu_top_properties (
  // Clock and reset
  input wire logic                       clk_sys_in,
  input wire logic                       rst_n_in,
  // APB slave
  input wire logic                       psel_in,
  input wire logic                       penable_in,
  input wire logic                       pwrite_in,
  input wire logic [cwu_pkg::APB_AW-1:0] paddr_in,
  input wire logic [cwu_pkg::APB_DW-1:0] prdata_out,
  input wire logic                       pready_out,
  input wire logic                       pslverr_out,
  // Pins
  input wire logic                       out_a_out,
  input wire logic                       out_b_out,
  input wire logic                       out_c_out,
  input wire logic                       out_d_out,
  input wire logic                       out_a_oe_out,
  input wire logic                       out_b_oe_out,
  input wire logic                       out_c_oe_out,
  input wire logic                       out_d_oe_out
);
  import cwu_pkg::*;
  wire       acc  = psel_in && penable_in;
  wire       wacc = acc && pwrite_in;
  wire [3:0] pins = {out_d_out, out_c_out, out_b_out, out_a_out};
  wire [3:0] oes  = {out_d_oe_out, out_c_oe_out, out_b_oe_out, out_a_oe_out};
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);

  chk_ready_high: assert property (pready_out)
    else $error("pready not high");
  chk_err_phase: assert property (pslverr_out |-> acc)
    else $error("error outside access phase");
  chk_err_status: assert property (wacc && paddr_in == OFS_STATUS
    |-> pslverr_out)
    else $error("status write not refused");
  chk_err_unmap: assert property (acc && paddr_in > OFS_STATUS |-> pslverr_out)
    else $error("unmapped access not refused");
  chk_ok_mapped: assert property (acc && !pwrite_in && paddr_in <= OFS_STATUS
    && paddr_in[1:0] == 2'h0 |-> !pslverr_out)
    else $error("mapped read refused");
  chk_err_rdzero: assert property (pslverr_out && !pwrite_in
    |-> prdata_out == 32'h0)
    else $error("refused read not zero");
  chk_idle_pin_low: assert property (
    (pins & ~oes) == 4'h0)
    else $error("undriven pin not low");
  chk_oe_rise_write: assert property ((oes & ~$past(oes)) != 4'h0
    |-> $past(wacc, 2)) else $error("drive enable rose without write");
  chk_oe_fall_write: assert property ((~oes & $past(oes)) != 4'h0
    |-> $past(wacc, 2)) else $error("drive enable fell without write");
endmodule : cwu_top_properties
bind cwu_top cwu_top_properties u_props (.*);
`default_nettype wire

// File: testbench/cwu_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
module cwu_top_tb;
  import cwu_pkg::*;
  logic        clk_sys_in, rst_n_in, psel_in, penable_in, pwrite_in;
  logic [7:0]  paddr_in;
  logic [31:0] pwdata_in, prdata_out, rdata;
  logic        pready_out, pslverr_out, err, shutdown_evt_in, arm, overlap;
  logic [15:0] wave_src_in;
  logic        out_a_out, out_b_out, out_c_out, out_d_out;
  logic        out_a_oe_out, out_b_oe_out, out_c_oe_out, out_d_oe_out;
  logic [3:0]  seen;
  int          mismatches, samples_checked, cycles;
  wire [3:0] pins = {out_d_out, out_c_out, out_b_out, out_a_out};
  wire [3:0] oes = {out_d_oe_out, out_c_oe_out, out_b_oe_out, out_a_oe_out};

  cwu_top dut (.*);
  cwu_bridge_model u_leg (.clk_sys_in, .rst_n_in, .arm_in(arm),
    .pins_in(pins), .overlap_out(overlap));

  always #4 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles > 20000) begin
      mismatches++;
      wrap_up();
    end
  end

  task wrap_up();
    if (mismatches == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : wrap_up

  task cmp(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask : cmp

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    psel_in <= 1'b1; penable_in <= 1'b0;
    pwrite_in <= w; paddr_in <= a; pwdata_in <= d;
    @(posedge clk_sys_in);
    penable_in <= 1'b1;
    do @(posedge clk_sys_in); while (pready_out !== 1'b1);
    rdata = prdata_out;
    err = pslverr_out;
    psel_in <= 1'b0; penable_in <= 1'b0;
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d); apb(1'b1, a, d);
  endtask : wr
  task rd(input logic [7:0] a); apb(1'b0, a, 32'h0);
  endtask : rd
  task src(input logic [15:0] v); @(posedge clk_sys_in); wave_src_in <= v;
  endtask : src
  task at(input int n); repeat (n) @(posedge clk_sys_in); @(negedge clk_sys_in);
  endtask : at
  task hold(input int n);
    repeat (n) begin
      @(negedge clk_sys_in);
      seen = seen | pins;
    end
  endtask : hold
  function logic [31:0] c0(input logic [2:0] m, input logic ld);
    return {27'h0, ld, m, 1'b1};
  endfunction : c0
  task pulse(input logic [3:0] e);
    seen = 4'h0; src(16'h1); hold(8); src(16'h0); hold(8); cmp(seen, e);
  endtask : pulse

  task t_regs();
    cmp({oes, pins}, 8'h0);
    for (int i = 0; i < 8; i++) begin
      rd(8'(i * 4)); cmp(rdata, (i == 1) ? 32'hF : 32'h0); cmp(err, 1'b0);
    end
    rd(8'h40);
    cmp(err, 1'b1);
    cmp(rdata, 32'h0);
    wr(OFS_STATUS, 32'hFF); cmp(err, 1'b1);
  endtask : t_regs

  task t_half();
    wr(OFS_RISE_DB, 32'h3); wr(OFS_FALL_DB, 32'h2); rd(OFS_STATUS);
    cmp(rdata[21:8], 14'h0203);
    wr(OFS_PIN_DRIVE_EN, 32'hF); wr(OFS_WAVE_CTRL0, c0(CWU_HALF_BRIDGE, 0));
    arm <= 1'b1;
    src(16'h0); at(6);
    cmp({oes, pins}, 8'hFA);
    src(16'h1); at(3); cmp(pins, 4'h0);
    at(3); cmp(pins, 4'h5);
    src(16'h0); at(3); cmp(pins, 4'h0);
    at(3); cmp(pins, 4'hA);
    seen = 4'h0; src(16'h1); at(1); src(16'h0); hold(12);
    cmp(seen[0], 1'b0);
    cmp(overlap, 1'b0);
    arm = 1'b0; wr(OFS_WAVE_CTRL1, 32'hB); src(16'h1); at(8);
    cmp(pins, 4'h1);
    src(16'h0); at(8); cmp(pins, 4'hE);
    wr(OFS_WAVE_CTRL0, 32'h0); at(3); cmp({oes, pins}, 8'h0);
  endtask : t_half

  task t_pp();
    wr(OFS_WAVE_CTRL1, 32'hF); wr(OFS_WAVE_CTRL0, c0(CWU_PUSH_PULL, 0));
    pulse(4'h5);
    @(posedge clk_sys_in); shutdown_evt_in <= 1'b1;
    @(posedge clk_sys_in); shutdown_evt_in <= 1'b0;
    pulse(4'h5);
    pulse(4'hA);
    wr(OFS_WAVE_CTRL0, 32'h0);
  endtask : t_pp

  task t_fb();
    wr(OFS_WAVE_CTRL0, c0(CWU_FB_FWD, 0)); src(16'h0); at(4);
    cmp(pins, 4'h1);
    src(16'h1); at(12); cmp(pins, 4'h9);
    wr(OFS_WAVE_CTRL0, c0(CWU_FB_REV, 0)); at(2);
    cmp(pins, 4'h9);
    src(16'h0); at(4); src(16'h1); at(3); cmp(pins, 4'h4);
    at(5); cmp(pins, 4'h6);
    wr(OFS_WAVE_CTRL0, c0(CWU_FB_FWD, 0)); src(16'h0); at(4);
    src(16'h1); at(3); cmp(pins, 4'h1);
    at(2); cmp(pins, 4'h9);
    wr(OFS_WAVE_CTRL0, 32'h0); src(16'h0);
  endtask : t_fb

  task t_steer();
    wr(OFS_WAVE_CTRL1, 32'hC); wr(OFS_STEERING, 32'h41);
    wr(OFS_WAVE_CTRL0, c0(CWU_STEER_ASYNC, 0)); at(3);
    cmp(pins, 4'h5);
    for (int i = 0; i < 16; i++) begin
      wr(OFS_INPUT_SEL, i); src(16'h1 << i); at(3);
      cmp(out_a_out, 1'b0);
    end
    wr(OFS_INPUT_SEL, 32'h0); src(16'h0); wr(OFS_STEERING, 32'h43); at(3);
    cmp(pins, 4'h7);
    wr(OFS_WAVE_CTRL0, c0(CWU_STEER_SYNC, 0)); wr(OFS_STEERING, 32'h41);
    at(6); cmp(pins, 4'h7);
    src(16'h1); at(4); src(16'h0); at(4); cmp(pins, 4'h5);
    wr(OFS_WAVE_CTRL0, 32'h0);
  endtask : t_steer

  task t_load();
    wr(OFS_WAVE_CTRL1, 32'hF); wr(OFS_WAVE_CTRL0, c0(CWU_HALF_BRIDGE, 0));
    wr(OFS_RISE_DB, 32'h7); wr(OFS_WAVE_CTRL0, c0(CWU_HALF_BRIDGE, 1));
    rd(OFS_STATUS); cmp(rdata[13:8], 6'h3);
    rd(OFS_WAVE_CTRL0); cmp(rdata[4], 1'b1);
    src(16'h1); at(6); src(16'h0); at(6);
    rd(OFS_STATUS); cmp(rdata[13:8], 6'h7);
    rd(OFS_WAVE_CTRL0); cmp(rdata[4], 1'b0);
    src(16'h1); at(7); cmp(out_a_out, 1'b0);
    at(4); cmp(out_a_out, 1'b1);
    wr(OFS_WAVE_CTRL0, 32'h0); src(16'h0);
  endtask : t_load

  task t_clk();
    wr(OFS_CLOCK_SEL, 32'h1); wr(OFS_RISE_DB, 32'h2);
    wr(OFS_WAVE_CTRL0, c0(CWU_HALF_BRIDGE, 0)); at(40);
    src(16'h1); at(10); cmp(out_a_out, 1'b0);
    at(40); cmp(out_a_out, 1'b1);
    wr(OFS_WAVE_CTRL0, 32'h0); wr(OFS_CLOCK_SEL, 32'h0); src(16'h0);
  endtask : t_clk

  initial begin
    clk_sys_in = 1'b0; rst_n_in = 1'b0; psel_in = 1'b0; penable_in = 1'b0;
    pwrite_in = 1'b0; paddr_in = 8'h00; pwdata_in = 32'h0; arm = 1'b0;
    wave_src_in = 16'h0; shutdown_evt_in = 1'b0;
    mismatches = 0; samples_checked = 0; cycles = 0;
    repeat (8) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    t_regs();
    t_half();
    t_pp();
    t_fb();
    t_steer();
    t_load();
    t_clk();
    wrap_up();
  end
endmodule : cwu_top_tb
`default_nettype wire

// File: verilog/cwu_pkg.sv
`default_nettype none
package cwu_pkg;

  // Bus geometry
  localparam int          APB_AW        = 8;
  localparam int          APB_DW        = 32;

  // Register byte offsets
  localparam logic [7:0]  OFS_WAVE_CTRL0   = 8'h00;
  localparam logic [7:0]  OFS_WAVE_CTRL1   = 8'h04;
  localparam logic [7:0]  OFS_CLOCK_SEL    = 8'h08;
  localparam logic [7:0]  OFS_INPUT_SEL    = 8'h0C;
  localparam logic [7:0]  OFS_RISE_DB      = 8'h10;
  localparam logic [7:0]  OFS_FALL_DB      = 8'h14;
  localparam logic [7:0]  OFS_STEERING     = 8'h18;
  localparam logic [7:0]  OFS_PIN_DRIVE_EN = 8'h1C;
  localparam logic [7:0]  OFS_STATUS       = 8'h20;

  // Field positions in wave_ctrl0
  localparam int          CTRL0_EN_BIT     = 0;
  localparam int          CTRL0_MODE_LSB   = 1;
  localparam int          CTRL0_LOAD_BIT   = 4;
  // Field positions in steering_ctrl_reg
  localparam int          STEER_SEL_LSB    = 0;
  localparam int          STEER_LVL_LSB    = 4;

  // Widths
  localparam int          DB_W             = 6;
  localparam int          NUM_OUT          = 4;
  localparam int          NUM_SRC          = 16;

  // Reset values
  localparam logic [3:0]  RST_INVERT_SEL   = 4'hF;
  localparam logic [3:0]  RST_INPUT_SEL    = 4'h0;
  localparam logic [5:0]  RST_DEADBAND     = 6'h00;
  localparam logic [3:0]  RST_STEER        = 4'h0;
  localparam logic [3:0]  RST_PIN_EN       = 4'h0;

  // Module clock rates, in MHz
  localparam logic [7:0]  SYS_CLK_MHZ      = 8'h7D;
  localparam logic [7:0]  FAST_OSC_MHZ     = 8'h10;

  // Operating modes
  typedef enum logic [2:0] {
    CWU_STEER_ASYNC = 3'h0,
    CWU_STEER_SYNC  = 3'h1,
    CWU_FB_FWD      = 3'h2,
    CWU_FB_REV      = 3'h3,
    CWU_HALF_BRIDGE = 3'h4,
    CWU_PUSH_PULL   = 3'h5
  } cwu_mode_t;

endpackage : cwu_pkg
`default_nettype wire

// File: verilog/cwu_top.sv
// Contract
// RULE_01: Half-bridge drives A as true and B as inverted input, with dead band.
// RULE_02: Half-bridge drives C and D like A and B, own polarity each.
// RULE_03: Push-pull sends input pulses alternately to A and B, first on A.
// RULE_04: Push-pull sequencer resets while disabled or on shutdown event.
// RULE_05: Push-pull C and D copy A and B with their own polarity.
// RULE_06: Forward full-bridge: A active, B and C inactive, D modulated.
// RULE_07: Reverse full-bridge: C active, A and D inactive, B modulated.
// RULE_08: Direction flips by mode bit 0 alone while running.
// RULE_09: After direction change A and C switch at rise; modulated delayed.
// RULE_10: Sync steering updates at next rising input; async at once.
// RULE_11: One select bit picks system clock or 16 MHz oscillator tick.
// RULE_12: Input-select register picks one of sixteen waveform sources.
// RULE_13: Each output has its own enable; clear means no pin control.
// RULE_14: While module disabled, enables and drive levels have no effect.
// RULE_15: Polarity bit set is active-high; overrides and steering unaffected.
// RULE_16: Two 6-bit counters: rising/reverse and falling/forward dead band.
// RULE_17: Dead band counts module clocks from zero up to register value.
// RULE_18: Half-bridge count sets delay from normal fall to inverted rise.
// RULE_19: Rise value delays A (half) or B (full); fall delays B or D.
// RULE_20: Dead bands double-buffered: direct when disabled, else load bit.
// RULE_21: Input pulse shorter than dead band gives no output pulse.
// RULE_22: Dead-band delay varies by at most one module clock period.
// RULE_23: Mode 000 is async steering, 001 is sync steering.
// RULE_24: Steer bit 0 holds fixed level; 1 follows data with polarity.
// RULE_25: Load bit clears itself once buffered values transfer.
//
// Added by the designer: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module cwu_top (
  // Clock and reset
  input  wire logic                        clk_sys_in,
  input  wire logic                        rst_n_in,
  // APB slave
  input  wire logic                        psel_in,
  input  wire logic                        penable_in,
  input  wire logic                        pwrite_in,
  input  wire logic [cwu_pkg::APB_AW-1:0]  paddr_in,
  input  wire logic [cwu_pkg::APB_DW-1:0]  pwdata_in,
  output logic      [cwu_pkg::APB_DW-1:0]  prdata_out,
  output logic                             pready_out,
  output logic                             pslverr_out,
  // Waveform sources and shutdown
  input  wire logic [cwu_pkg::NUM_SRC-1:0] wave_src_in,
  input  wire logic                        shutdown_evt_in,
  // Output pins
  output logic                             out_a_out,
  output logic                             out_b_out,
  output logic                             out_c_out,
  output logic                             out_d_out,
  output logic                             out_a_oe_out,
  output logic                             out_b_oe_out,
  output logic                             out_c_oe_out,
  output logic                             out_d_oe_out
);
  import cwu_pkg::*;

  // Register state
  logic                 en_q;
  cwu_mode_t            mode_q;
  logic                 load_q;
  logic [NUM_OUT-1:0]   invert_sel_q;
  logic                 clk_sel_q;
  logic [3:0]           input_sel_q;
  logic [DB_W-1:0]      rise_buf_q;
  logic [DB_W-1:0]      fall_buf_q;
  logic [DB_W-1:0]      rise_work_q;
  logic [DB_W-1:0]      fall_work_q;
  logic [NUM_OUT-1:0]   steer_reg_q;
  logic [NUM_OUT-1:0]   steer_lvl_q;
  logic [NUM_OUT-1:0]   pin_en_q;

  // Datapath state
  logic [7:0]           osc_acc_q;
  logic [7:0]           osc_sum;
  logic                 tick;
  logic                 data_raw;
  logic                 data_q;
  logic                 rise_evt;
  logic                 fall_evt;
  logic                 db_xfer;
  logic                 fb_mode;
  logic                 steer_mode;
  logic                 pp_phase_q;
  logic                 dir_q;
  logic                 dir_pend_q;
  logic [NUM_OUT-1:0]   steer_act_q;
  logic [NUM_OUT-1:0]   raw;
  logic [NUM_OUT-1:0]   pin_q;
  logic [NUM_OUT-1:0]   oe_q;
  logic [DB_W-1:0]      db_cnt_q [2];
  logic [DB_W-1:0]      db_lim   [2];
  logic [1:0]           db_hold;
  logic [1:0]           db_next;
  logic [1:0]           db_ok;

  // APB decode
  logic                 apb_setup;
  logic                 apb_wr;
  logic [APB_DW-1:0]    rd_mux;
  logic                 rd_hit;
  logic [APB_DW-1:0]    prdata_q;
  logic                 pslverr_q;

  assign apb_setup  = psel_in & ~penable_in;
  assign apb_wr     = psel_in & penable_in & pwrite_in;
  assign pready_out = 1'b1;
  assign prdata_out = prdata_q;
  assign pslverr_out = pslverr_q & psel_in & penable_in;

  always_comb begin
    rd_mux = '0;
    rd_hit = 1'b1;
    case (paddr_in)
      OFS_WAVE_CTRL0: begin
        rd_mux[CTRL0_EN_BIT]                  = en_q;
        rd_mux[CTRL0_MODE_LSB +: 3]           = mode_q;
        rd_mux[CTRL0_LOAD_BIT]                = load_q;
      end
      OFS_WAVE_CTRL1:   rd_mux[NUM_OUT-1:0]   = invert_sel_q;
      OFS_CLOCK_SEL:    rd_mux[0]             = clk_sel_q;
      OFS_INPUT_SEL:    rd_mux[3:0]           = input_sel_q;
      OFS_RISE_DB:      rd_mux[DB_W-1:0]      = rise_buf_q;
      OFS_FALL_DB:      rd_mux[DB_W-1:0]      = fall_buf_q;
      OFS_STEERING: begin
        rd_mux[STEER_SEL_LSB +: NUM_OUT]      = steer_reg_q;
        rd_mux[STEER_LVL_LSB +: NUM_OUT]      = steer_lvl_q;
      end
      OFS_PIN_DRIVE_EN: rd_mux[NUM_OUT-1:0]   = pin_en_q;
      OFS_STATUS: begin
        rd_mux[NUM_OUT-1:0]                   = pin_q;
        rd_mux[4]                             = data_q;
        rd_mux[5]                             = pp_phase_q;
        rd_mux[6]                             = dir_q;
        rd_mux[7]                             = dir_pend_q;
        rd_mux[8 +: DB_W]                     = rise_work_q;
        rd_mux[16 +: DB_W]                    = fall_work_q;
      end
      default:          rd_hit                = 1'b0;
    endcase
  end

  // Read data and error are captured in the setup cycle
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prdata_q  <= '0;
      pslverr_q <= 1'b0;
    end else if (apb_setup) begin
      prdata_q  <= pwrite_in ? '0 : rd_mux;
      pslverr_q <= ~rd_hit | (pwrite_in && paddr_in == OFS_STATUS);
    end
  end

  // Software-written configuration
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      en_q         <= 1'b0;
      mode_q       <= CWU_STEER_ASYNC;
      invert_sel_q <= RST_INVERT_SEL;
      clk_sel_q    <= 1'b0;
      input_sel_q  <= RST_INPUT_SEL;
      rise_buf_q   <= RST_DEADBAND;
      fall_buf_q   <= RST_DEADBAND;
      steer_reg_q  <= RST_STEER;
      steer_lvl_q  <= RST_STEER;
      pin_en_q     <= RST_PIN_EN;
    end else if (apb_wr) begin
      case (paddr_in)
        OFS_WAVE_CTRL0: begin
          en_q   <= pwdata_in[CTRL0_EN_BIT];
          mode_q <= cwu_mode_t'(pwdata_in[CTRL0_MODE_LSB +: 3]);
        end
        OFS_WAVE_CTRL1:   invert_sel_q <= pwdata_in[NUM_OUT-1:0];
        OFS_CLOCK_SEL:    clk_sel_q    <= pwdata_in[0]; // [RULE_11]
        OFS_INPUT_SEL:    input_sel_q  <= pwdata_in[3:0];
        OFS_RISE_DB:      rise_buf_q   <= pwdata_in[DB_W-1:0];
        OFS_FALL_DB:      fall_buf_q   <= pwdata_in[DB_W-1:0];
        OFS_STEERING: begin
          steer_reg_q <= pwdata_in[STEER_SEL_LSB +: NUM_OUT];
          steer_lvl_q <= pwdata_in[STEER_LVL_LSB +: NUM_OUT];
        end
        OFS_PIN_DRIVE_EN: pin_en_q     <= pwdata_in[NUM_OUT-1:0];
        default: ;
      endcase
    end
  end

  // Load request: a software set wins over the hardware clear
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      load_q <= 1'b0;
    end else if (apb_wr && paddr_in == OFS_WAVE_CTRL0) begin
      load_q <= pwdata_in[CTRL0_LOAD_BIT];
    end else if (db_xfer) begin
      load_q <= 1'b0; // [RULE_25]
    end
  end

  // Working dead-band values
  assign db_xfer = en_q & load_q & fall_evt; // [RULE_20]
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rise_work_q <= RST_DEADBAND;
      fall_work_q <= RST_DEADBAND;
    end else if (db_xfer) begin
      rise_work_q <= rise_buf_q; // [RULE_20]
      fall_work_q <= fall_buf_q;
    end else if (!en_q && apb_wr) begin
      if (paddr_in == OFS_RISE_DB) begin
        rise_work_q <= pwdata_in[DB_W-1:0]; // [RULE_20]
      end
      if (paddr_in == OFS_FALL_DB) begin
        fall_work_q <= pwdata_in[DB_W-1:0];
      end
    end
  end

  // Module clock tick: every cycle, or a 16 MHz rate by phase accumulation
  assign osc_sum = osc_acc_q + FAST_OSC_MHZ;
  assign tick    = ~clk_sel_q | (osc_sum >= SYS_CLK_MHZ); // [RULE_11]
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      osc_acc_q <= '0;
    end else if (!clk_sel_q) begin
      osc_acc_q <= '0;
    end else if (osc_sum >= SYS_CLK_MHZ) begin
      osc_acc_q <= osc_sum - SYS_CLK_MHZ;
    end else begin
      osc_acc_q <= osc_sum;
    end
  end

  // Input selection and sampling on the module clock
  assign data_raw = wave_src_in[input_sel_q]; // [RULE_12]
  assign rise_evt = tick & data_raw & ~data_q;
  assign fall_evt = tick & ~data_raw & data_q;
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      data_q <= 1'b0;
    end else if (tick) begin
      data_q <= data_raw; // [RULE_22]
    end
  end

  assign fb_mode    = (mode_q == CWU_FB_FWD) | (mode_q == CWU_FB_REV);
  assign steer_mode = (mode_q == CWU_STEER_ASYNC) |
                      (mode_q == CWU_STEER_SYNC);

  // Counter 0: rising or reverse; counter 1: falling or forward
  assign db_lim[0]  = rise_work_q; // [RULE_16]
  assign db_lim[1]  = fall_work_q;
  assign db_hold[0] = data_q;
  assign db_next[0] = data_raw;
  assign db_hold[1] = fb_mode ? data_q : ~data_q;
  assign db_next[1] = fb_mode ? data_raw : ~data_raw;

  for (genvar k = 0; k < 2; k++) begin : g_db
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        db_cnt_q[k] <= '0;
      end else if (tick) begin
        if (!db_next[k]) begin
          db_cnt_q[k] <= '0;
        end else if (db_hold[k] && db_cnt_q[k] < db_lim[k]) begin
          db_cnt_q[k] <= db_cnt_q[k] + 6'h01; // [RULE_17]
        end
      end
    end
    assign db_ok[k] = db_hold[k] & (db_cnt_q[k] >= db_lim[k]); // [RULE_21]
  end

  // Push-pull sequencer
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pp_phase_q <= 1'b0;
    end else if (!en_q || shutdown_evt_in) begin
      pp_phase_q <= 1'b0; // [RULE_04]
    end else if (mode_q == CWU_PUSH_PULL && fall_evt) begin
      pp_phase_q <= ~pp_phase_q; // [RULE_03]
    end
  end

  // Full-bridge direction, applied at a rising input edge
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dir_q      <= 1'b0;
      dir_pend_q <= 1'b0;
    end else if (fb_mode && rise_evt) begin
      dir_q      <= mode_q[0]; // [RULE_08]
      dir_pend_q <= dir_q ^ mode_q[0]; // [RULE_09]
    end else if (fall_evt) begin
      dir_pend_q <= 1'b0;
    end
  end

  // Steering selection: at once, or at a rising input edge
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      steer_act_q <= RST_STEER;
    end else if (mode_q == CWU_STEER_ASYNC) begin
      steer_act_q <= steer_reg_q; // [RULE_10] [RULE_23]
    end else if (mode_q == CWU_STEER_SYNC && rise_evt) begin
      steer_act_q <= steer_reg_q; // [RULE_10] [RULE_23]
    end
  end

  // Active-high waveforms per mode, before polarity
  always_comb begin
    raw = '0;
    case (mode_q)
      CWU_HALF_BRIDGE: begin
        raw[0] = db_ok[0]; // [RULE_01] [RULE_19]
        raw[1] = db_ok[1]; // [RULE_18] [RULE_19]
        raw[2] = db_ok[0]; // [RULE_02]
        raw[3] = db_ok[1];
      end
      CWU_PUSH_PULL: begin
        raw[0] = data_q & ~pp_phase_q; // [RULE_03]
        raw[1] = data_q & pp_phase_q;
        raw[2] = data_q & ~pp_phase_q; // [RULE_05]
        raw[3] = data_q & pp_phase_q;
      end
      CWU_FB_FWD, CWU_FB_REV: begin
        if (!dir_q) begin
          raw[0] = 1'b1; // [RULE_06]
          raw[3] = dir_pend_q ? db_ok[1] : data_q; // [RULE_06] [RULE_19]
        end else begin
          raw[2] = 1'b1; // [RULE_07]
          raw[1] = dir_pend_q ? db_ok[0] : data_q; // [RULE_07] [RULE_19]
        end
      end
      CWU_STEER_ASYNC, CWU_STEER_SYNC: begin
        raw = {NUM_OUT{data_q}};
      end
      default: raw = '0;
    endcase
  end

  // Output stage per pin
  for (genvar i = 0; i < NUM_OUT; i++) begin : g_pin
    logic pol_val;
    logic pin_d;
    assign pol_val = invert_sel_q[i] ? raw[i] : ~raw[i]; // [RULE_15]
    always_comb begin
      if (!en_q || !pin_en_q[i]) begin
        pin_d = 1'b0; // [RULE_13] [RULE_14]
      end else if (steer_mode && !steer_act_q[i]) begin
        pin_d = steer_lvl_q[i]; // [RULE_24]
      end else begin
        pin_d = pol_val; // [RULE_24]
      end
    end
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        pin_q[i] <= 1'b0;
        oe_q[i]  <= 1'b0;
      end else begin
        pin_q[i] <= pin_d;
        oe_q[i]  <= en_q & pin_en_q[i]; // [RULE_13] [RULE_14]
      end
    end
  end

  assign out_a_out    = pin_q[0];
  assign out_b_out    = pin_q[1];
  assign out_c_out    = pin_q[2];
  assign out_d_out    = pin_q[3];
  assign out_a_oe_out = oe_q[0];
  assign out_b_oe_out = oe_q[1];
  assign out_c_oe_out = oe_q[2];
  assign out_d_oe_out = oe_q[3];

endmodule : cwu_top
`default_nettype wire
